// ===== pkg/fqp_pkg.sv
// ============================================================================
// Package of the flash query and program controller
// ============================================================================
// Holds command codes, status bit positions, bus timing counts, the expected
// extended query table and the structs that carry requests and answers.
// Assumes a 50 MHz clock and a x16-configured flash on the pins.
package fqp_pkg;

  localparam int CLK_NS = 20;
  localparam int ADDR_W = 23;
  localparam int DQ_W   = 16;
  localparam int CNT_W  = 12;
  localparam int TMO_W  = 20;

  // Bus timing, times in ns and the derived clock counts.
  localparam int T_WE_NS   = 70;
  localparam int T_RD_NS   = 150;
  localparam int T_REC_NS  = 30;
  localparam int T_RP_NS   = 25000;
  localparam int T_PROG_NS = 2000000;
  localparam logic [CNT_W-1:0] WE_CYC  = CNT_W'((T_WE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] RD_CYC  = CNT_W'((T_RD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] REC_CYC = CNT_W'((T_REC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] RP_CYC  = CNT_W'((T_RP_NS + CLK_NS - 1) / CLK_NS);
  localparam int               PROG_CYC = T_PROG_NS / CLK_NS;

  // Command codes written to the flash.
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_CLR_STATUS = 8'h50;
  localparam logic [7:0] CMD_QUERY      = 8'h98;

  // Operation status bit positions.
  localparam int MACHINE_READY_POS = 7;
  localparam int PROGRAM_ERR_POS   = 4;
  localparam int VOLTAGE_ERR_POS   = 3;
  localparam int PROTECT_ERR_POS   = 1;

  // Query locations.
  localparam logic [ADDR_W-1:0] QRY_PTR_ADDR = 23'h000015;
  localparam logic [DQ_W-1:0]   EXT_PTR_VAL  = 16'h0031;
  localparam logic [4:0]        EXT_LAST_IDX = 5'h15;
  localparam logic [7:0]        DQ_HI_ZERO   = 8'h00;

  typedef enum logic [2:0] {
    FQP_OP_PROGRAM,
    FQP_OP_QUERY,
    FQP_OP_TABLE_CHECK,
    FQP_OP_CLEAR,
    FQP_OP_ARRAY
  } fqp_op_t;

  typedef struct packed {
    fqp_op_t           op;
    logic              last;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0]   data;
  } fqp_req_t;

  typedef struct packed {
    logic [7:0]      status;
    logic [DQ_W-1:0] rdata;
    logic            match;
    logic            error;
    logic            timeout;
  } fqp_rsp_t;

  typedef struct packed {
    logic              rp_n;
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0]   dq_out;
    logic              dq_oe_n;
  } fqp_pins_t;

  // Expected extended table byte by index from its start: {care, value}.
  // Bytes 10h to 12h vary with the part and are not compared.
  function automatic logic [8:0] ext_expect(input logic [4:0] idx);
    logic [8:0] e;
    e = {1'b1, 8'h00};
    unique case (idx)
      5'h00: e = {1'b1, 8'h50};
      5'h01: e = {1'b1, 8'h52};
      5'h02: e = {1'b1, 8'h49};
      5'h03: e = {1'b1, 8'h31};
      5'h04: e = {1'b1, 8'h31};
      5'h05: e = {1'b1, 8'h0A};
      5'h09: e = {1'b1, 8'h01};
      5'h0A: e = {1'b1, 8'h01};
      5'h0C: e = {1'b1, 8'h33};
      5'h0D: e = {1'b1, 8'h00};
      5'h0E: e = {1'b1, 8'h01};
      5'h10: e = {1'b0, 8'h00};
      5'h11: e = {1'b0, 8'h00};
      5'h12: e = {1'b0, 8'h00};
      5'h13: e = {1'b1, 8'h03};
      default: e = {1'b1, 8'h00};
    endcase
    return e;
  endfunction

endpackage

// ===== logic/fqp_ctrl.sv
// ============================================================================
// Flash query and program controller
// ============================================================================
// Drives an asynchronous x16 NOR flash through its pins: program with status
// polling, query reads, an extended table check, clear status, read array.
// Assumes the flash pins are sampled synchronously to clk.
//
// What this block does
// [RQ1] Check extended table starts with P R I.
// [RQ2] Check both version bytes read 31h.
// [RQ3] Check feature field reads 0A 00 00 00.
// [RQ4] Feature bits checked through the 0Ah byte.
// [RQ5] Check after-suspend byte reads 01.
// [RQ6] Check block status mask reads 01 00.
// [RQ7] Check voltage bytes read 33 then 00.
// [RQ8] Check one protection field is reported.
// [RQ9] Check page-mode byte reads 03.
// [RQ10] Check synchronous field count reads 00.
// [RQ11] Locate extended table through pointer at 15h.
// [RQ12] Program: write 40h then data, same address.
// [RQ13] Poll ready bit until it reads one; the code stops polling when the program timeout is reached.
// [RQ14] Poll by toggling output enable, no command.
// [RQ15] Report voltage error bit from status.
// [RQ16] Report protect error bit from status.
// [RQ17] Report program error bit from status.
// [RQ18] Error bits persist until clear-status command.
// [RQ19] Clear status after any detected error.
// [RQ20] Write FFh after the last program; the code writes none when that program times out.
// [RQ21] Upper query data byte must be zero.
// [RQ22] Device wakes in array read mode.
// [RQ23] Reset pin low clears device status.
// [RQ24] Reserved table bytes must read zero.
`timescale 1ns/1ps

module fqp_ctrl
  import fqp_pkg::*;
#(
  parameter int PROG_TIMEOUT_CYC = fqp_pkg::PROG_CYC
) (
  // Clock and reset.
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // User request port.
  input  wire logic                    req_valid,
  input  wire fqp_pkg::fqp_req_t       req,
  output logic                         req_ready,
  // User answer port.
  output logic                         rsp_valid,
  output fqp_pkg::fqp_rsp_t            rsp,
  // Flash pins.
  output logic                         reset_powerdown_n,
  output logic                         flash_ce_n,
  output logic                         flash_oe_n,
  output logic                         flash_we_n,
  output logic [fqp_pkg::ADDR_W-1:0]   flash_addr,
  output logic [fqp_pkg::DQ_W-1:0]     flash_dq_out,
  output logic                         flash_dq_oe_n,
  input  wire logic [fqp_pkg::DQ_W-1:0] flash_dq_in
);
  import fqp_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef enum logic [2:0] {
    S_RESET, S_WAKE, S_IDLE, S_WR, S_WR_REC, S_RD, S_RD_REC
  } fqp_st_t;

  typedef enum logic [3:0] {
    P_SETUP, P_DATA, P_POLL, P_CLR_ERR, P_FINISH,
    P_QCMD, P_QRD, P_TCMD, P_TPTR, P_TRD
  } fqp_ph_t;

  typedef struct packed {
    fqp_st_t           st;
    fqp_ph_t           ph;
    fqp_req_t          req;
    logic [DQ_W-1:0]   bdata;
    logic [CNT_W-1:0]  cnt;
    logic [TMO_W-1:0]  tmo;
    logic              tmo_hit;
    logic [4:0]        idx;
    logic [7:0]        ptr;
    logic              match;
    fqp_pins_t         pins;
    logic              req_ready;
    logic              rsp_valid;
    fqp_rsp_t          rsp;
  } fqp_state_t;

  localparam logic [TMO_W-1:0] TMO_LIM = TMO_W'(PROG_TIMEOUT_CYC);

  fqp_state_t state_ff;
  fqp_state_t nxt_state;

  function automatic fqp_state_t reset_val();
    fqp_state_t r;
    r              = '0;
    r.st           = S_RESET;
    r.pins.rp_n    = 1'b0;
    r.pins.ce_n    = 1'b1;
    r.pins.oe_n    = 1'b1;
    r.pins.we_n    = 1'b1;
    r.pins.dq_oe_n = 1'b1;
    return r;
  endfunction

  // Starts a write cycle; address and data stand from its first cycle.
  function automatic fqp_state_t go_wr(input fqp_state_t s, input logic [ADDR_W-1:0] a,
                                       input logic [DQ_W-1:0] d);
    fqp_state_t r;
    r              = s;
    r.st           = S_WR;
    r.cnt          = '0;
    r.pins.addr    = a;
    r.pins.dq_out  = d;
    r.pins.dq_oe_n = 1'b0;
    r.pins.ce_n    = 1'b0;
    r.pins.we_n    = 1'b0;
    return r;
  endfunction

  // Starts a read cycle with the data lines released.
  function automatic fqp_state_t go_rd(input fqp_state_t s, input logic [ADDR_W-1:0] a);
    fqp_state_t r;
    r              = s;
    r.st           = S_RD;
    r.cnt          = '0;
    r.pins.addr    = a;
    r.pins.dq_oe_n = 1'b1;
    r.pins.ce_n    = 1'b0;
    r.pins.oe_n    = 1'b0;
    return r;
  endfunction

  // Ends the operation and posts the answer.
  function automatic fqp_state_t finish(input fqp_state_t s);
    fqp_state_t r;
    r             = s;
    r.st          = S_IDLE;
    r.req_ready   = 1'b1;
    r.rsp_valid   = 1'b1;
    r.rsp.rdata   = s.bdata;
    r.rsp.match   = s.match;
    r.rsp.timeout = s.tmo_hit;
    r.rsp.error   = s.rsp.status[PROGRAM_ERR_POS] | s.rsp.status[VOLTAGE_ERR_POS] |
                    s.rsp.status[PROTECT_ERR_POS] | s.tmo_hit;
    return r;
  endfunction

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    logic [8:0]       exp_b;
    logic [4:0]       nidx;
    logic             err;
    exp_b = ext_expect(state_ff.idx);
    nidx  = state_ff.idx + 5'h01;
    err   = 1'b0;
    nxt_state           = state_ff;
    nxt_state.rsp_valid = 1'b0;
    nxt_state.cnt       = state_ff.cnt + CNT_W'(1);
    if (state_ff.tmo != TMO_LIM) begin
      nxt_state.tmo = state_ff.tmo + TMO_W'(1);
    end
    unique case (state_ff.st)
      S_RESET: begin
        if (state_ff.cnt == RP_CYC - CNT_W'(1)) begin
          nxt_state.pins.rp_n = 1'b1; // RQ23
          nxt_state.st        = S_WAKE;
          nxt_state.cnt       = '0;
        end
      end
      S_WAKE: begin
        if (state_ff.cnt == RP_CYC - CNT_W'(1)) begin
          nxt_state.st        = S_IDLE; // RQ22
          nxt_state.req_ready = 1'b1;
        end
      end
      S_IDLE: begin
        nxt_state.cnt = '0;
        if (req_valid) begin
          nxt_state.req       = req;
          nxt_state.req_ready = 1'b0;
          nxt_state.match     = 1'b1;
          nxt_state.tmo_hit   = 1'b0;
          nxt_state.rsp       = '0;
          nxt_state.bdata     = '0;
          unique case (req.op)
            FQP_OP_PROGRAM: begin
              nxt_state    = go_wr(nxt_state, req.addr, {DQ_HI_ZERO, CMD_PROG_SETUP}); // RQ12
              nxt_state.ph = P_SETUP;
            end
            FQP_OP_QUERY: begin
              nxt_state    = go_wr(nxt_state, req.addr, {DQ_HI_ZERO, CMD_QUERY});
              nxt_state.ph = P_QCMD;
            end
            FQP_OP_TABLE_CHECK: begin
              nxt_state    = go_wr(nxt_state, req.addr, {DQ_HI_ZERO, CMD_QUERY});
              nxt_state.ph = P_TCMD;
            end
            FQP_OP_CLEAR: begin
              nxt_state    = go_wr(nxt_state, req.addr, {DQ_HI_ZERO, CMD_CLR_STATUS});
              nxt_state.ph = P_FINISH;
            end
            default: begin
              nxt_state    = go_wr(nxt_state, req.addr, {DQ_HI_ZERO, CMD_READ_ARRAY});
              nxt_state.ph = P_FINISH;
            end
          endcase
        end
      end
      S_WR: begin
        if (state_ff.cnt == WE_CYC - CNT_W'(1)) begin
          nxt_state.pins.we_n = 1'b1;
          nxt_state.pins.ce_n = 1'b1;
          nxt_state.st        = S_WR_REC;
          nxt_state.cnt       = '0;
        end
      end
      S_WR_REC: begin
        if (state_ff.cnt == REC_CYC - CNT_W'(1)) begin
          nxt_state.pins.dq_oe_n = 1'b1;
          unique case (state_ff.ph)
            P_SETUP: begin
              nxt_state    = go_wr(nxt_state, state_ff.req.addr, state_ff.req.data); // RQ12
              nxt_state.ph = P_DATA;
            end
            P_DATA: begin
              nxt_state.tmo = '0;
              nxt_state     = go_rd(nxt_state, state_ff.req.addr);
              nxt_state.ph  = P_POLL;
            end
            P_QCMD: begin
              nxt_state    = go_rd(nxt_state, state_ff.req.addr);
              nxt_state.ph = P_QRD;
            end
            P_TCMD: begin
              nxt_state    = go_rd(nxt_state, QRY_PTR_ADDR); // RQ11
              nxt_state.ph = P_TPTR;
            end
            P_CLR_ERR: begin
              if (state_ff.req.last) begin
                nxt_state    = go_wr(nxt_state, state_ff.req.addr,
                                     {DQ_HI_ZERO, CMD_READ_ARRAY}); // RQ20
                nxt_state.ph = P_FINISH;
              end else begin
                nxt_state = finish(nxt_state);
              end
            end
            default: begin
              nxt_state = finish(nxt_state);
            end
          endcase
        end
      end
      S_RD: begin
        if (state_ff.cnt == RD_CYC - CNT_W'(1)) begin
          nxt_state.bdata     = flash_dq_in;
          nxt_state.pins.oe_n = 1'b1; // RQ14
          nxt_state.pins.ce_n = 1'b1;
          nxt_state.st        = S_RD_REC;
          nxt_state.cnt       = '0;
        end
      end
      S_RD_REC: begin
        if (state_ff.cnt == REC_CYC - CNT_W'(1)) begin
          unique case (state_ff.ph)
            P_POLL: begin
              nxt_state.rsp.status = state_ff.bdata[7:0];
              err = state_ff.bdata[PROGRAM_ERR_POS] | state_ff.bdata[VOLTAGE_ERR_POS] |
                    state_ff.bdata[PROTECT_ERR_POS]; // RQ15 RQ16 RQ17 RQ18
              if (state_ff.bdata[MACHINE_READY_POS]) begin // RQ13
                if (err) begin
                  nxt_state    = go_wr(nxt_state, state_ff.req.addr,
                                       {DQ_HI_ZERO, CMD_CLR_STATUS}); // RQ19
                  nxt_state.ph = P_CLR_ERR;
                end else if (state_ff.req.last) begin
                  nxt_state    = go_wr(nxt_state, state_ff.req.addr,
                                       {DQ_HI_ZERO, CMD_READ_ARRAY}); // RQ20
                  nxt_state.ph = P_FINISH;
                end else begin
                  nxt_state = finish(nxt_state);
                end
              end else if (state_ff.tmo == TMO_LIM) begin
                nxt_state.tmo_hit = 1'b1;
                nxt_state         = finish(nxt_state);
              end else begin
                nxt_state = go_rd(nxt_state, state_ff.req.addr); // RQ14
              end
            end
            P_QRD: begin
              nxt_state.match = (state_ff.bdata[15:8] == DQ_HI_ZERO); // RQ21
              nxt_state       = finish(nxt_state);
            end
            P_TPTR: begin
              nxt_state.ptr   = state_ff.bdata[7:0]; // RQ11
              nxt_state.match = (state_ff.bdata == EXT_PTR_VAL);
              nxt_state.idx   = '0;
              nxt_state       = go_rd(nxt_state, ADDR_W'(state_ff.bdata[7:0]));
              nxt_state.ph    = P_TRD;
            end
            P_TRD: begin
              // Covers signature, versions, features, masks, voltages,
              // protection count, page size, burst count and reserved byte.
              if (exp_b[8] && state_ff.bdata != {DQ_HI_ZERO, exp_b[7:0]}) begin
                nxt_state.match = 1'b0; // RQ1 RQ2 RQ3 RQ4 RQ5 RQ6 RQ7 RQ8 RQ9 RQ10 RQ24
              end
              if (state_ff.idx == EXT_LAST_IDX) begin
                nxt_state = finish(nxt_state);
              end else begin
                nxt_state.idx = nidx;
                nxt_state     = go_rd(nxt_state, ADDR_W'(state_ff.ptr + {3'b000, nidx}));
              end
            end
            default: begin
              nxt_state = finish(nxt_state);
            end
          endcase
        end
      end
      default: begin
        nxt_state = reset_val();
      end
    endcase
  end

  // ==========================================================================
  // Registers and outputs
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= reset_val();
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign req_ready         = state_ff.req_ready;
  assign rsp_valid         = state_ff.rsp_valid;
  assign rsp               = state_ff.rsp;
  assign reset_powerdown_n = state_ff.pins.rp_n;
  assign flash_ce_n        = state_ff.pins.ce_n;
  assign flash_oe_n        = state_ff.pins.oe_n;
  assign flash_we_n        = state_ff.pins.we_n;
  assign flash_addr        = state_ff.pins.addr;
  assign flash_dq_out      = state_ff.pins.dq_out;
  assign flash_dq_oe_n     = state_ff.pins.dq_oe_n;

endmodule

// ===== dv/fqp_flash_model.sv
// Behavioural x16 flash: query table, word program, status, clear.
// Assumes pins sampled on clk; err_inj and busy_len are set by the bench.
`timescale 1ns/1ps
module fqp_flash_model
  import fqp_pkg::*;
(
  // Clock and pins.
  input  wire logic              clk,
  input  wire fqp_pkg::fqp_pins_t pins,
  output logic [fqp_pkg::DQ_W-1:0] dq_in,
  // Bench controls and observation.
  input  wire logic [7:0]         err_inj,
  input  wire logic [15:0]        busy_len,
  output logic [1:0]              mode_ff,
  output logic [7:0]              err_ff,
  output logic [15:0]             prog_ff
);
  // ==========================================================================
  // Command interface and status
  logic [15:0] busy_ff = '0;
  logic [7:0]  stat_ff = '0;
  logic        we_q    = 1'b1;
  logic        oe_q    = 1'b1;
  logic [15:0] d_q     = '0;
  logic [15:0] last_ff = '0;
  logic [15:0] rd;
  function automatic logic [7:0] qb(input logic [22:0] a);
    case (a)
      23'h15: return 8'h31;
      23'h31: return 8'h50;
      23'h32: return 8'h52;
      23'h33: return 8'h49;
      23'h34, 23'h35: return 8'h31;
      23'h36: return 8'h0A;
      23'h3A, 23'h3B, 23'h3F, 23'h41: return 8'h01;
      23'h3D: return 8'h33;
      23'h42, 23'h44: return 8'h03;
      default: return 8'h00;
    endcase
  endfunction
  initial mode_ff = 2'h0;
  initial err_ff = 8'h00;
  initial prog_ff = 16'h0000;
  always @(posedge clk) begin
    we_q <= pins.we_n;
    oe_q <= pins.oe_n;
    d_q  <= pins.dq_out;
    if (busy_ff != 16'h0000) busy_ff <= busy_ff - 16'h0001;
    if (!pins.rp_n) begin
      mode_ff <= 2'h0;
      err_ff  <= 8'h00;
      busy_ff <= 16'h0000;
    end else if (!we_q && pins.we_n) begin
      if (mode_ff == 2'h3) begin
        busy_ff <= busy_len;
        err_ff  <= err_ff | (err_inj & 8'h1A);
        prog_ff <= d_q;
        mode_ff <= 2'h2;
      end else begin
        case (d_q[7:0])
          8'h40: mode_ff <= 2'h3;
          8'h50: err_ff <= 8'h00;
          8'h98: mode_ff <= 2'h1;
          8'hFF: mode_ff <= 2'h0;
          default: ;
        endcase
      end
    end
    if (oe_q && !pins.oe_n) stat_ff <= {busy_ff == 16'h0000, 2'b00, err_ff[4:0]};
    if (!pins.ce_n && !pins.oe_n) last_ff <= dq_in;
  end
  always_comb begin
    rd = {8'h00, qb(pins.addr)};
    if (mode_ff[1]) rd = {8'h00, stat_ff};
    if (mode_ff == 2'h0) rd = ~pins.addr[15:0];
    dq_in = (!pins.ce_n && !pins.oe_n) ? rd : ~last_ff;
  end
endmodule

// ===== dv/fqp_ctrl_checker.sv
// Port-level assertions for the flash query and program controller.
// Assumes the fqp_ctrl port list and a bind at the foot of this file.
`timescale 1ns/1ps
module fqp_ctrl_checker
  import fqp_pkg::*;
#(
  parameter int PROG_TIMEOUT_CYC = 200
) (
  // Clock and reset.
  input wire logic                      clk,
  input wire logic                      rst_n,
  // User side.
  input wire logic                      req_valid,
  input wire fqp_pkg::fqp_req_t         req,
  input wire logic                      req_ready,
  input wire logic                      rsp_valid,
  input wire fqp_pkg::fqp_rsp_t         rsp,
  // Flash pins.
  input wire logic                      reset_powerdown_n,
  input wire logic                      flash_ce_n,
  input wire logic                      flash_oe_n,
  input wire logic                      flash_we_n,
  input wire logic [fqp_pkg::ADDR_W-1:0] flash_addr,
  input wire logic [fqp_pkg::DQ_W-1:0]  flash_dq_out,
  input wire logic                      flash_dq_oe_n,
  input wire logic [fqp_pkg::DQ_W-1:0]  flash_dq_in
);
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_reset_hold: assert property (
    $rose(rst_n) |-> (!reset_powerdown_n && !req_ready) [*8]
  ) else $error("flash reset or ready released too early");
  a_ready_drop: assert property (
    req_valid && req_ready |=> !req_ready
  ) else $error("ready stayed high after accept");
  a_rsp_pulse: assert property (
    rsp_valid |-> req_ready ##1 !rsp_valid
  ) else $error("answer pulse malformed");
  a_we_width: assert property (
    $fell(flash_we_n) |-> (!flash_we_n && !flash_ce_n && !flash_dq_oe_n) [*4] ##1 flash_we_n
  ) else $error("write strobe width wrong");
  a_oe_toggle: assert property (
    $fell(flash_oe_n) |-> !flash_oe_n [*8] ##1 flash_oe_n [*2]
  ) else $error("read strobe toggle wrong");
  a_no_fight: assert property (
    !flash_oe_n |-> flash_dq_oe_n && flash_we_n
  ) else $error("data driven during read");
  a_prog_setup: assert property (
    req_valid && req_ready && req.op == FQP_OP_PROGRAM |->
      ##[1:3] (!flash_we_n && flash_dq_out[7:0] == CMD_PROG_SETUP)
  ) else $error("program setup not written");
  a_clear_cmd: assert property (
    req_valid && req_ready && req.op == FQP_OP_CLEAR |->
      ##[1:3] (!flash_we_n && flash_dq_out[7:0] == CMD_CLR_STATUS)
  ) else $error("clear status not written");
  a_array_cmd: assert property (
    req_valid && req_ready && req.op == FQP_OP_ARRAY |->
      ##[1:3] (!flash_we_n && flash_dq_out[7:0] == CMD_READ_ARRAY)
  ) else $error("read array not written");
  c_program: cover property (req_valid && req_ready && req.op == FQP_OP_PROGRAM);
  c_timeout: cover property (rsp_valid && rsp.timeout);
  c_error: cover property (rsp_valid && rsp.error && !rsp.timeout);
endmodule
bind fqp_ctrl fqp_ctrl_checker #(.PROG_TIMEOUT_CYC(PROG_TIMEOUT_CYC)) fqp_ctrl_checker_inst (
  .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .rsp(rsp), .reset_powerdown_n(reset_powerdown_n),
  .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
  .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
  .flash_dq_in(flash_dq_in));

// ===== dv/testbench.sv
// Self-checking bench: controller against the behavioural flash model.
// Assumes a 50 MHz clock and a shortened program timeout.
`timescale 1ns/1ps
module testbench;
  import fqp_pkg::*;
  // ==========================================================================
  // Signals, design and model
  logic      clk = 1'b0;
  logic      rst_n = 1'b0;
  logic      req_valid = 1'b0;
  fqp_req_t  req = '0;
  logic      req_ready;
  logic      rsp_valid;
  fqp_rsp_t  rsp;
  wire fqp_pins_t pins;
  logic [15:0] dq_in;
  logic [7:0]  err_inj = 8'h00;
  logic [15:0] busy_len = 16'd20;
  logic [1:0]  mode;
  logic [7:0]  dev_err;
  logic [15:0] prog_data;
  int errors = 0;
  int total_checks = 0;
  int bpos[3] = '{4, 3, 1};
  always #10 clk = ~clk;
  fqp_ctrl #(.PROG_TIMEOUT_CYC(200)) fqp_ctrl_inst (
    .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .reset_powerdown_n(pins.rp_n),
    .flash_ce_n(pins.ce_n), .flash_oe_n(pins.oe_n), .flash_we_n(pins.we_n),
    .flash_addr(pins.addr), .flash_dq_out(pins.dq_out), .flash_dq_oe_n(pins.dq_oe_n),
    .flash_dq_in(dq_in));
  fqp_flash_model fqp_flash_model_inst (
    .clk(clk), .pins(pins), .dq_in(dq_in), .err_inj(err_inj), .busy_len(busy_len),
    .mode_ff(mode), .err_ff(dev_err), .prog_ff(prog_data));
  // ==========================================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 4000) errors++;
  endtask
  task automatic run(input fqp_op_t op, input logic last, input logic [22:0] a,
                     input logic [15:0] d);
    int n;
    wait_ready();
    req_valid = 1'b1;
    req = '{op: op, last: last, addr: a, data: d};
    @(negedge clk);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 5000) errors++;
    $display("test %s done", op.name());
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================================
  // Tests
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    finish_test();
  end
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    wait_ready();
    chk("flash reset pin", 32'(pins.rp_n), 32'h1);
    run(FQP_OP_TABLE_CHECK, 1'b0, 23'h0, 16'h0);
    chk("table match", 32'({rsp.match, rsp.error}), 32'h2);
    run(FQP_OP_QUERY, 1'b0, 23'h15, 16'h0);
    chk("table pointer", 32'(rsp.rdata), 32'h31);
    run(FQP_OP_QUERY, 1'b0, 23'h44, 16'h0);
    chk("page byte", 32'({rsp.rdata, rsp.match}), 32'h7);
    run(FQP_OP_QUERY, 1'b0, 23'h46, 16'h0);
    chk("reserved byte", 32'(rsp.rdata), 32'h0);
    run(FQP_OP_ARRAY, 1'b0, 23'h0, 16'h0);
    chk("array mode", 32'(mode), 32'h0);
    run(FQP_OP_PROGRAM, 1'b1, 23'h123, 16'hA5C3);
    chk("program status", 32'({rsp.status, rsp.error}), 32'h100);
    chk("programmed data", 32'(prog_data), 32'hA5C3);
    chk("mode after program", 32'(mode), 32'h0);
    for (int i = 0; i < 3; i++) begin
      err_inj = 8'h01 << bpos[i];
      run(FQP_OP_PROGRAM, 1'b0, 23'h200, 16'h5A00);
      chk("error status", 32'({rsp.status, rsp.error}), 32'({8'h80 | err_inj, 1'b1}));
      chk("device errors cleared", 32'(dev_err), 32'h0);
    end
    err_inj = 8'h00;
    busy_len = 16'd1000;
    run(FQP_OP_PROGRAM, 1'b1, 23'h300, 16'h0F0F);
    chk("timeout flags", 32'({rsp.timeout, rsp.error}), 32'h3);
    @(negedge clk);
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    busy_len = 16'd20;
    wait_ready();
    chk("mode after reset", 32'(mode), 32'h0);
    run(FQP_OP_CLEAR, 1'b0, 23'h0, 16'h0);
    chk("clear answer", 32'({rsp.error, rsp.timeout}), 32'h0);
    finish_test();
  end
endmodule
